// ===== logic/acc_consts.svh
// register offsets, field positions, reset values and timing figures of the channel control block
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

`define ACC_OFS_GEN 6'h00
`define ACC_OFS_STAT 6'h04
`define ACC_OFS_PINF 6'h08
`define ACC_OFS_DIR 6'h0c
`define ACC_OFS_DRV 6'h10
`define ACC_OFS_OUTL 6'h14
`define ACC_OFS_INL 6'h18
`define ACC_OFS_SEQ 6'h1c
`define ACC_OFS_RES 6'h20
`define ACC_OFS_THR 6'h24
`define ACC_OFS_ADDR 6'h28
`define ACC_OFS_CRC 6'h2c

`define ACC_GEN_CAL 0
`define ACC_GEN_RST 1
`define ACC_GEN_AUTO 2
`define ACC_GEN_AVG 3
`define ACC_GEN_START 4
`define ACC_STAT_READY 0
`define ACC_STAT_BUSY 1
`define ACC_STAT_ALERT 2
`define ACC_STAT_CAL 3
`define ACC_CRC_CLR 8

`define ACC_ADDR_BASE 7'h10
`define ACC_THR_HI_RST 12'hfff
`define ACC_THR_LO_RST 12'h000
`define ACC_SAR_MID 12'h800
`define ACC_SAR_TOP 4'hb
`define ACC_AVG_LAST 4'hf
`define ACC_CRC_POLY 8'h07
`define ACC_RESP_OK 2'b00
`define ACC_RESP_ERR 2'b10

`define ACC_CLK_MHZ 125
`define ACC_CLK_NS 8
`define ACC_T_PU_MS 5
`define ACC_T_RST_MS 5
`define ACC_T_ACQ_NS 300
`define ACC_ACQ_CYC ((`ACC_T_ACQ_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_SETTLE_CYC 5
`define ACC_STRAP_CYC 20'h5

`endif

// ===== logic/acc_pkg.sv
// types shared by the channel control block
package acc_pkg;

	typedef enum logic [3:0] {
		ACC_IDLE = 4'h1,
		ACC_ACQ = 4'h2,
		ACC_TRY = 4'h4,
		ACC_DONE = 4'h8
	} acc_state_t;

	typedef struct packed {
		logic [7:0] pin_func;
		logic [7:0] dir;
		logic [7:0] drive;
		logic [7:0] out_lvl;
		logic cal;
		logic auto_en;
		logic avg_en;
		logic start;
		logic [7:0] auto_sel;
		logic [2:0] man_ch;
		logic [11:0] thr_hi;
		logic [11:0] thr_lo;
	} acc_cfg_t;

	typedef struct packed {
		logic [7:0] ch_s1;
		logic [7:0] ch_s2;
		logic [7:0] ch_s3;
		logic [7:0] ch_lvl;
		logic cmp_s1;
		logic cmp_s2;
		logic cmp_s3;
		logic cmp_lvl;
		logic [2:0] adr_s1;
		logic [2:0] adr_s2;
		logic [2:0] adr_s3;
		logic [2:0] adr_lvl;
		acc_cfg_t cfg;
		logic rst;
		logic ready;
		logic [19:0] timer;
		logic alert;
		logic [6:0] bus_addr;
		logic [7:0] crc;
		acc_state_t st;
		logic [2:0] ch;
		logic [11:0] code;
		logic [3:0] bitn;
		logic [5:0] wait_cnt;
		logic cal_run;
		logic [11:0] offset;
		logic [15:0] acc;
		logic [3:0] navg;
		logic [15:0] result;
		logic [2:0] res_ch;
		logic aw_ok;
		logic w_ok;
		logic [5:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} acc_regs_t;

endpackage

// ===== logic/acc_ctrl.sv
// channel configuration, conversion sequencing and register slave of the eight-channel converter
`timescale 1ns/1ps
`default_nettype none
`include "acc_consts.svh"

module acc_ctrl #(
	parameter int PU_CYCLES = `ACC_T_PU_MS * `ACC_CLK_MHZ * 1000,
	parameter int RST_CYCLES = `ACC_T_RST_MS * `ACC_CLK_MHZ * 1000,
	parameter int ADDR_W = 6
) (
	input wire logic CLK, // block clock, 125 MHz
	input wire logic NRST, // asynchronous reset, active low
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // write address
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic [1:0] S_AXI_BRESP, // write response
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // read address
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_RREADY, // read data ready
	input wire logic [7:0] CH_IN, // channel pin levels
	output logic [7:0] CH_OUT, // channel pin output values
	output logic [7:0] CH_OE, // channel pin output enables
	input wire logic COMP_IN, // comparator, high when input is at or above the trial code
	output logic [11:0] DAC_CODE, // trial code of the successive approximation
	output logic [2:0] MUX_SEL, // channel routed to the sampler
	output logic SAMPLE, // sampling switch closed
	output logic CAL_ZERO, // sampler tied to ground for offset calibration
	input wire logic [2:0] ADDR_STRAP, // decoded strap: bit2 upper resistor, bits1:0 value
	output logic [6:0] BUS_ADDR, // serial bus address in use
	output logic SCL_STRETCH_OE, // holds the serial clock low during a host conversion
	output logic ALERT, // threshold alert to the host
	output logic READY // device operational
);
	import acc_pkg::*;

	localparam logic [19:0] PU_LAST = 20'(PU_CYCLES - 1);
	localparam logic [19:0] RST_LAST = 20'(RST_CYCLES - 1);
	localparam logic [5:0] ACQ_LAST = 6'(`ACC_ACQ_CYC - 1);
	localparam logic [5:0] SETTLE_LAST = 6'(`ACC_SETTLE_CYC - 1);

	localparam acc_cfg_t CFG_RST = '{
		thr_hi: `ACC_THR_HI_RST,
		thr_lo: `ACC_THR_LO_RST,
		default: '0
	};

	localparam acc_regs_t REGS_RST = '{
		cfg: CFG_RST,
		st: ACC_IDLE,
		bus_addr: `ACC_ADDR_BASE,
		bresp: `ACC_RESP_OK,
		rresp: `ACC_RESP_OK,
		default: '0
	};

	acc_regs_t s_q;
	acc_regs_t s_d;

	// next analog channel after c among those in m, wrapping round
	function automatic logic [2:0] next_ch(input logic [7:0] m, input logic [2:0] c);
		logic [2:0] r;
		logic found;
		logic [2:0] idx;
		r = c;
		found = 1'b0;
		for (int k = 1; k <= 8; k++) begin
			idx = 3'(c + 3'(k));
			if (!found && m[idx]) begin
				r = idx;
				found = 1'b1;
			end
		end
		return r;
	endfunction

	// one byte through the crc, polynomial x^8 + x^2 + x + 1
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int k = 0; k < 8; k++) begin
			r = r[7] ? ((r << 1) ^ `ACC_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = cur;
		for (int k = 0; k < 4; k++) begin
			if (be[k]) begin
				r[k*8 +: 8] = wd[k*8 +: 8];
			end
		end
		return r;
	endfunction

	// bit 32 marks a mapped offset
	function automatic logic [32:0] rd_word(input acc_regs_t s, input logic [5:0] a);
		logic [32:0] r;
		r = {1'b1, 32'h0};
		case ({a[5:2], 2'b00})
			`ACC_OFS_GEN: begin
				r[`ACC_GEN_CAL] = s.cfg.cal;
				r[`ACC_GEN_RST] = s.rst;
				r[`ACC_GEN_AUTO] = s.cfg.auto_en;
				r[`ACC_GEN_AVG] = s.cfg.avg_en;
				r[`ACC_GEN_START] = s.cfg.start;
			end
			`ACC_OFS_STAT: begin
				r[`ACC_STAT_READY] = s.ready;
				r[`ACC_STAT_BUSY] = (s.st != ACC_IDLE);
				r[`ACC_STAT_ALERT] = s.alert;
				r[`ACC_STAT_CAL] = s.cal_run;
				r[14:8] = s.bus_addr;
			end
			`ACC_OFS_PINF: r[7:0] = s.cfg.pin_func;
			`ACC_OFS_DIR: r[7:0] = s.cfg.dir;
			`ACC_OFS_DRV: r[7:0] = s.cfg.drive;
			`ACC_OFS_OUTL: r[7:0] = s.cfg.out_lvl;
			`ACC_OFS_INL: r[7:0] = s.ch_lvl & s.cfg.pin_func & ~s.cfg.dir;
			`ACC_OFS_SEQ: begin
				r[7:0] = s.cfg.auto_sel;
				r[10:8] = s.cfg.man_ch;
			end
			`ACC_OFS_RES: begin
				r[15:0] = s.result;
				r[18:16] = s.res_ch;
			end
			`ACC_OFS_THR: begin
				r[11:0] = s.cfg.thr_lo;
				r[27:16] = s.cfg.thr_hi;
			end
			`ACC_OFS_ADDR: r[6:0] = s.bus_addr;
			`ACC_OFS_CRC: r[7:0] = s.crc;
			default: r = {1'b0, 32'h0};
		endcase
		return r;
	endfunction

	always_comb begin
		logic [7:0] anl_auto;
		logic [11:0] corr;
		logic [11:0] cmp12;
		logic [15:0] res;
		logic alert_hit;
		logic soft_go;
		logic [32:0] cur;
		logic [31:0] wm;
		anl_auto = 8'h0;
		corr = 12'h0;
		cmp12 = 12'h0;
		res = 16'h0;
		alert_hit = 1'b0;
		soft_go = 1'b0;
		cur = 33'h0;
		wm = 32'h0;
		s_d = s_q;

		// a pin level counts once the second and third stage agree
		s_d.ch_s1 = CH_IN;
		s_d.ch_s2 = s_q.ch_s1;
		s_d.ch_s3 = s_q.ch_s2;
		s_d.ch_lvl = (s_q.ch_s2 & s_q.ch_s3) | (s_q.ch_lvl & (s_q.ch_s2 ^ s_q.ch_s3));
		s_d.cmp_s1 = COMP_IN;
		s_d.cmp_s2 = s_q.cmp_s1;
		s_d.cmp_s3 = s_q.cmp_s2;
		s_d.cmp_lvl = (s_q.cmp_s2 & s_q.cmp_s3) | (s_q.cmp_lvl & (s_q.cmp_s2 ^ s_q.cmp_s3));
		s_d.adr_s1 = ADDR_STRAP;
		s_d.adr_s2 = s_q.adr_s1;
		s_d.adr_s3 = s_q.adr_s2;
		s_d.adr_lvl = (s_q.adr_s2 & s_q.adr_s3) | (s_q.adr_lvl & (s_q.adr_s2 ^ s_q.adr_s3));

		// power-up and soft reset delay; the strap is caught once the filter has settled
		if (!s_q.ready) begin
			s_d.timer = s_q.timer + 20'h1;
			if (s_q.timer == `ACC_STRAP_CYC) begin
				s_d.bus_addr = `ACC_ADDR_BASE | {4'h0, s_q.adr_lvl};
			end
			if (s_q.rst ? (s_q.timer == RST_LAST) : (s_q.timer == PU_LAST)) begin
				s_d.ready = 1'b1;
				s_d.rst = 1'b0;
			end
		end

		// successive approximation sequencer
		anl_auto = s_q.cfg.auto_sel & ~s_q.cfg.pin_func;
		case (s_q.st)
			ACC_IDLE: begin
				s_d.wait_cnt = 6'h0;
				s_d.navg = 4'h0;
				s_d.acc = 16'h0;
				if (s_q.ready) begin
					if (s_q.cfg.cal) begin
						s_d.cal_run = 1'b1;
						s_d.st = ACC_ACQ;
					end else if (s_q.cfg.auto_en && (anl_auto != 8'h0)) begin
						s_d.ch = next_ch(anl_auto, s_q.ch);
						s_d.st = ACC_ACQ;
					end else if (s_q.cfg.start) begin
						s_d.ch = s_q.cfg.man_ch;
						s_d.st = ACC_ACQ;
					end
				end
			end
			ACC_ACQ: begin
				s_d.code = `ACC_SAR_MID;
				s_d.bitn = `ACC_SAR_TOP;
				s_d.wait_cnt = s_q.wait_cnt + 6'h1;
				if (s_q.wait_cnt == ACQ_LAST) begin
					s_d.wait_cnt = 6'h0;
					s_d.st = ACC_TRY;
				end
			end
			ACC_TRY: begin
				// the comparator reaches us through three stages, so each trial waits for it
				s_d.wait_cnt = s_q.wait_cnt + 6'h1;
				if (s_q.wait_cnt == SETTLE_LAST) begin
					s_d.wait_cnt = 6'h0;
					if (!s_q.cmp_lvl) begin
						s_d.code[s_q.bitn] = 1'b0;
					end
					if (s_q.bitn == 4'h0) begin
						s_d.st = ACC_DONE;
					end else begin
						s_d.bitn = s_q.bitn - 4'h1;
						s_d.code[4'(s_q.bitn - 4'h1)] = 1'b1;
					end
				end
			end
			ACC_DONE: begin
				// straight binary, floored at 000 after offset removal
				corr = (s_q.code > s_q.offset) ? (s_q.code - s_q.offset) : 12'h000;
				if (s_q.cal_run) begin
					s_d.offset = s_q.code;
					s_d.cal_run = 1'b0;
					s_d.cfg.cal = 1'b0;
					s_d.st = ACC_IDLE;
				end else if (s_q.cfg.avg_en && (s_q.navg != `ACC_AVG_LAST)) begin
					s_d.acc = s_q.acc + {4'h0, corr};
					s_d.navg = s_q.navg + 4'h1;
					s_d.st = ACC_ACQ;
				end else begin
					res = s_q.cfg.avg_en ? (s_q.acc + {4'h0, corr}) : {4'h0, corr};
					s_d.result = res;
					s_d.res_ch = s_q.ch;
					cmp12 = s_q.cfg.avg_en ? res[15:4] : corr;
					alert_hit = (cmp12 > s_q.cfg.thr_hi) || (cmp12 < s_q.cfg.thr_lo);
					s_d.cfg.start = 1'b0;
					s_d.st = ACC_IDLE;
				end
			end
			default: s_d.st = ACC_IDLE;
		endcase

		// write channel: address and data are held until both have arrived
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			s_d.aw_ok = 1'b1;
			s_d.awaddr = 6'(S_AXI_AWADDR);
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			s_d.w_ok = 1'b1;
			s_d.wdata = S_AXI_WDATA;
			s_d.wstrb = S_AXI_WSTRB;
		end
		if (s_q.bvalid && S_AXI_BREADY) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
			cur = rd_word(s_q, s_q.awaddr);
			wm = merge(cur[31:0], s_q.wdata, s_q.wstrb);
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = cur[32] ? `ACC_RESP_OK : `ACC_RESP_ERR;
			case ({s_q.awaddr[5:2], 2'b00})
				`ACC_OFS_GEN: begin
					if (wm[`ACC_GEN_RST]) begin
						soft_go = 1'b1;
					end else begin
						// writes only set the self-clearing bits, so a write in the finishing cycle wins
						if (wm[`ACC_GEN_CAL]) begin
							s_d.cfg.cal = 1'b1;
						end
						if (wm[`ACC_GEN_START]) begin
							s_d.cfg.start = 1'b1;
						end
						s_d.cfg.auto_en = wm[`ACC_GEN_AUTO];
						s_d.cfg.avg_en = wm[`ACC_GEN_AVG];
					end
				end
				`ACC_OFS_STAT: begin
					// write one to clear: the merged read-back must not clear it when the byte is not written
					if (s_q.wstrb[0] && s_q.wdata[`ACC_STAT_ALERT]) begin
						s_d.alert = 1'b0;
					end
				end
				`ACC_OFS_PINF: s_d.cfg.pin_func = wm[7:0];
				`ACC_OFS_DIR: s_d.cfg.dir = wm[7:0];
				`ACC_OFS_DRV: s_d.cfg.drive = wm[7:0];
				`ACC_OFS_OUTL: s_d.cfg.out_lvl = wm[7:0];
				`ACC_OFS_SEQ: begin
					s_d.cfg.auto_sel = wm[7:0];
					s_d.cfg.man_ch = wm[10:8];
				end
				`ACC_OFS_THR: begin
					s_d.cfg.thr_lo = wm[11:0];
					s_d.cfg.thr_hi = wm[27:16];
				end
				`ACC_OFS_ADDR: s_d.bus_addr = wm[6:0];
				`ACC_OFS_CRC: s_d.crc = crc8(wm[`ACC_CRC_CLR] ? 8'h00 : s_q.crc, wm[7:0]);
				default: s_d.bresp = cur[32] ? `ACC_RESP_OK : `ACC_RESP_ERR;
			endcase
		end

		// a threshold hit in the clearing cycle still raises the alert
		if (alert_hit) begin
			s_d.alert = 1'b1;
		end

		// soft reset brings configuration, state, alert, offset, result and the address strap back to their power-up values; the crc is kept
		if (soft_go) begin
			s_d.cfg = CFG_RST;
			s_d.rst = 1'b1;
			s_d.ready = 1'b0;
			s_d.timer = 20'h0;
			s_d.alert = 1'b0;
			s_d.st = ACC_IDLE;
			s_d.cal_run = 1'b0;
			s_d.offset = 12'h000;
			s_d.result = 16'h0;
			s_d.bus_addr = `ACC_ADDR_BASE;
		end

		// read channel answers one cycle after the address is taken
		if (s_q.rvalid && S_AXI_RREADY) begin
			s_d.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			cur = rd_word(s_q, 6'(S_AXI_ARADDR));
			s_d.rvalid = 1'b1;
			s_d.rdata = cur[31:0];
			s_d.rresp = cur[32] ? `ACC_RESP_OK : `ACC_RESP_ERR;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			s_q <= REGS_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// per-channel pin drive
	for (genvar gi = 0; gi < 8; gi++) begin : g_pin
		logic is_out;
		assign is_out = s_q.cfg.pin_func[gi] & s_q.cfg.dir[gi];
		assign CH_OUT[gi] = s_q.cfg.drive[gi] & s_q.cfg.out_lvl[gi];
		// open-drain only pulls low; push-pull drives both levels
		assign CH_OE[gi] = is_out & (s_q.cfg.drive[gi] | ~s_q.cfg.out_lvl[gi]);
	end

	assign S_AXI_AWREADY = !s_q.aw_ok && !s_q.bvalid;
	assign S_AXI_WREADY = !s_q.w_ok && !s_q.bvalid;
	assign S_AXI_BVALID = s_q.bvalid;
	assign S_AXI_BRESP = s_q.bresp;
	assign S_AXI_ARREADY = !s_q.rvalid;
	assign S_AXI_RVALID = s_q.rvalid;
	assign S_AXI_RDATA = s_q.rdata;
	assign S_AXI_RRESP = s_q.rresp;

	assign DAC_CODE = s_q.code;
	assign MUX_SEL = s_q.ch;
	assign SAMPLE = (s_q.st == ACC_ACQ);
	assign CAL_ZERO = s_q.cal_run;
	assign BUS_ADDR = s_q.bus_addr;
	// a whole host conversion, about 100 cycles or 1600 with averaging, fits inside the stretch
	assign SCL_STRETCH_OE = (s_q.st != ACC_IDLE) && !s_q.cal_run && !s_q.cfg.auto_en;
	assign ALERT = s_q.alert;
	assign READY = s_q.ready;

endmodule
`default_nettype wire

// ===== bench/acc_ctrl_assertions.sv
// port assertions of the channel control block
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_chk #(
	parameter int PU_CYCLES = 50,
	parameter int RST_CYCLES = 50
) (
	input wire logic CLK, // clock
	input wire logic NRST, // reset, active low
	input wire logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_ARVALID, // read address valid
	input wire logic S_AXI_ARREADY, // read address ready
	input wire logic S_AXI_RVALID, // read data valid
	input wire logic [7:0] CH_OUT, // pin values
	input wire logic [7:0] CH_OE, // pin enables
	input wire logic [11:0] DAC_CODE, // trial code
	input wire logic SAMPLE, // acquisition
	input wire logic CAL_ZERO, // calibration sampling
	input wire logic [2:0] ADDR_STRAP, // decoded strap
	input wire logic [6:0] BUS_ADDR, // bus address
	input wire logic SCL_STRETCH_OE, // clock stretch
	input wire logic ALERT, // alert
	input wire logic READY // operational
);
	localparam int LIM = (PU_CYCLES > RST_CYCLES ? PU_CYCLES : RST_CYCLES) + 4;
	int down_q;
	int str_q;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	// long spans are counted here so the properties stay small
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			down_q <= 0;
			str_q <= 0;
		end else begin
			down_q <= READY ? 0 : down_q + 1;
			str_q <= SCL_STRETCH_OE ? str_q + 1 : 0;
		end
	end
	property p_pins_analog; $rose(NRST) |-> CH_OE == 8'h00 && CH_OUT == 8'h00; endproperty
	a_pins_analog: assert property (p_pins_analog) else $error("pins driven after reset");
	property p_up_time; down_q <= LIM; endproperty
	a_up_time: assert property (p_up_time) else $error("ready came late");
	property p_strap; $rose(READY) |-> BUS_ADDR == {4'h2, ADDR_STRAP}; endproperty
	a_strap: assert property (p_strap) else $error("address not taken from strap");
	property p_addr_hold; READY && $past(READY) && !$rose(S_AXI_BVALID) |-> $stable(BUS_ADDR); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved while running");
	property p_stretch; str_q <= 1800; endproperty
	a_stretch: assert property (p_stretch) else $error("clock stretched too long");
	property p_sar_mid; $fell(SAMPLE) |-> ##[0:4] DAC_CODE == 12'h800; endproperty
	a_sar_mid: assert property (p_sar_mid) else $error("first trial not mid code");
	property p_cal_end; $rose(CAL_ZERO) |-> ##[1:200] !CAL_ZERO; endproperty
	a_cal_end: assert property (p_cal_end) else $error("calibration never ends");
	property p_alert_clr; $fell(ALERT) |-> S_AXI_BVALID || $past(S_AXI_BVALID); endproperty
	a_alert_clr: assert property (p_alert_clr) else $error("alert dropped without a write");
	property p_rd_lat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_ar_busy; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read taken while answer pending");
endmodule
bind acc_ctrl acc_ctrl_chk #(.PU_CYCLES(PU_CYCLES), .RST_CYCLES(RST_CYCLES)) acc_ctrl_chk_inst (
	.CLK(CLK), .NRST(NRST), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .CH_OUT(CH_OUT), .CH_OE(CH_OE),
	.DAC_CODE(DAC_CODE), .SAMPLE(SAMPLE), .CAL_ZERO(CAL_ZERO), .ADDR_STRAP(ADDR_STRAP),
	.BUS_ADDR(BUS_ADDR), .SCL_STRETCH_OE(SCL_STRETCH_OE), .ALERT(ALERT), .READY(READY)
);
`default_nettype wire

// ===== bench/acc_afe_model.sv
// analog front end and pin model facing the channel control block
`timescale 1ns/1ps
`default_nettype none
module acc_afe_model (
	input wire logic clk, // block clock
	input wire logic [95:0] levels, // analog level of each channel, 12 bits apiece
	input wire logic [7:0] ext_lvl, // level the outside puts on undriven pins
	input wire logic [11:0] dac_code, // trial code
	input wire logic [2:0] mux_sel, // converted channel
	input wire logic sample, // sampling switch
	input wire logic cal_zero, // sampler grounded
	input wire logic [7:0] ch_out, // pin values
	input wire logic [7:0] ch_oe, // pin enables
	output logic comp, // comparator
	output logic [7:0] ch_in // resolved pin levels
);
	logic [11:0] held_q = 12'h000;
	// the capacitor keeps its charge once the switch opens
	always_ff @(posedge clk) begin
		if (sample)
			held_q <= cal_zero ? 12'h000 : levels[mux_sel * 12 +: 12];
	end
	assign comp = held_q >= dac_code;
	assign ch_in = (ch_oe & ch_out) | (~ch_oe & ext_lvl);
endmodule
`default_nettype wire

// ===== bench/adc_channel_config_control_tb.sv
// self-checking bench of the channel control block
`timescale 1ns/1ps
`default_nettype none
`include "acc_consts.svh"
module adc_channel_config_control_tb;
	localparam int PU = 50;
	localparam int RS = 60;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [5:0] awaddr = 6'h00;
	logic [5:0] araddr = 6'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, comp, sample, cal_zero, stretch, alert, ready;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata;
	logic [31:0] seed = 32'h9dea;
	logic [7:0] ch_in, ch_out, ch_oe;
	logic [7:0] ext = 8'h00;
	logic [11:0] dac;
	logic [2:0] mux;
	logic [2:0] strap = 3'h5;
	logic [6:0] bus_addr;
	logic [95:0] lvls = 96'h0;
	int miscompares = 0;
	int compares = 0;
	acc_ctrl #(.PU_CYCLES(PU), .RST_CYCLES(RS)) acc_ctrl_inst (.CLK(clk), .NRST(nrst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .CH_IN(ch_in), .CH_OUT(ch_out), .CH_OE(ch_oe), .COMP_IN(comp),
		.DAC_CODE(dac), .MUX_SEL(mux), .SAMPLE(sample), .CAL_ZERO(cal_zero), .ADDR_STRAP(strap),
		.BUS_ADDR(bus_addr), .SCL_STRETCH_OE(stretch), .ALERT(alert), .READY(ready));
	acc_afe_model acc_afe_model_inst (.clk(clk), .levels(lvls), .ext_lvl(ext), .dac_code(dac),
		.mux_sel(mux), .sample(sample), .cal_zero(cal_zero), .ch_out(ch_out), .ch_oe(ch_oe),
		.comp(comp), .ch_in(ch_in));
	initial begin
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] x;
		x = c ^ b;
		for (int i = 0; i < 8; i++)
			x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
		return x;
	endfunction
	function automatic logic [7:0] oe_of(input logic [31:0] c);
		return c[7:0] & c[15:8] & (c[23:16] | ~c[31:24]);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// both bus tasks wait for the answer however long it takes; only the watchdog ends a hang
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	// sel picks ready, else the clock stretch output
	task automatic wt(input logic sel, input logic v, input int lim);
		int n;
		n = 0;
		while ((sel ? ready : stretch) !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(sel ? ready : stretch, v);
	endtask
	// result is read as soon as the stretch ends, so a late code shows up
	task automatic conv(input logic [2:0] ch, input logic [11:0] lv, input logic avg, output logic [31:0] d);
		lvls[ch * 12 +: 12] <= lv;
		wr(`ACC_OFS_SEQ, {21'h0, ch, 8'h00});
		wr(`ACC_OFS_GEN, {27'h0, 1'b1, avg, 3'h0});
		wt(1'b0, 1'b1, 40);
		wt(1'b0, 1'b0, 3000);
		rd(`ACC_OFS_RES, d);
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		$display("BAD %0t watchdog expired", $time);
		miscompares++;
		wrap_up();
	end
	initial begin
		logic [31:0] d;
		logic [31:0] c;
		logic [11:0] lv;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		wt(1'b1, 1'b1, PU + 20);
		chk(ready, 1'b1);
		chk(ch_oe, 8'h00);
		rd(`ACC_OFS_STAT, d);
		chk(resp, `ACC_RESP_OK);
		chk(d[14:8], {4'h2, strap});
		for (int a = 8; a < 24; a += 4) begin
			rd(a[5:0], d);
			chk(d, 32'h0);
		end
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			c = i == 0 ? 32'h330fffff : seed;
			ext <= c[7:0] ^ c[31:24];
			wr(`ACC_OFS_PINF, {24'h0, c[7:0]});
			wr(`ACC_OFS_DIR, {24'h0, c[15:8]});
			wr(`ACC_OFS_DRV, {24'h0, c[23:16]});
			wr(`ACC_OFS_OUTL, {24'h0, c[31:24]});
			rd(`ACC_OFS_INL, d);
			chk(d[7:0], (c[7:0] ^ c[31:24]) & c[7:0] & ~c[15:8]);
			chk(ch_oe, oe_of(c));
			chk(ch_out & oe_of(c), c[31:24] & oe_of(c));
		end
		wr(`ACC_OFS_PINF, 32'h0);
		wr(`ACC_OFS_GEN, 32'h1);
		d = 32'h1;
		for (int n = 0; n < 100 && d[0]; n++)
			rd(`ACC_OFS_GEN, d);
		chk(d[0], 1'b0);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			lv = i == 5 ? seed[11:0] : (i == 4 ? 12'hfff : {i[1], 10'h0, i[0]});
			conv(i[2:0] + 3'h1, lv, 1'b0, d);
			chk(d[11:0], lv);
			chk(d[18:16], i[2:0] + 3'h1);
		end
		chk(alert, 1'b0);
		wr(`ACC_OFS_THR, 32'h0f000100);
		for (int i = 0; i < 2; i++) begin
			conv(3'h7, i ? 12'h050 : 12'hfff, 1'b0, d);
			chk(alert, 1'b1);
			wr(`ACC_OFS_STAT, 32'h4);
			chk(alert, 1'b0);
		end
		lvls[35:24] <= 12'hfff;
		wr(`ACC_OFS_SEQ, 32'hc);
		wr(`ACC_OFS_GEN, 32'h4);
		for (int n = 0; n < 600 && alert !== 1'b1; n++)
			@(posedge clk);
		chk(alert, 1'b1);
		wr(`ACC_OFS_GEN, 32'h0);
		d = 32'h2;
		for (int n = 0; n < 100 && d[1]; n++)
			rd(`ACC_OFS_STAT, d);
		conv(3'h4, 12'h123, 1'b1, d);
		for (int n = 0; n < 800 && d[15:0] !== 16'h1230; n++)
			rd(`ACC_OFS_RES, d);
		chk(d[15:0], 16'h1230);
		wr(`ACC_OFS_CRC, 32'h1a5);
		wr(`ACC_OFS_CRC, 32'h3c);
		rd(`ACC_OFS_CRC, d);
		chk(d[7:0], crc8(crc8(8'h00, 8'ha5), 8'h3c));
		rd(6'h30, d);
		chk(d, 32'h0);
		chk(resp, `ACC_RESP_ERR);
		wr(6'h3c, 32'h1);
		chk(resp, `ACC_RESP_ERR);
		wr(`ACC_OFS_PINF, 32'hff);
		strap <= 3'h2;
		rd(`ACC_OFS_STAT, d);
		chk(d[14:8], 7'h15);
		wr(`ACC_OFS_ADDR, 32'h5a);
		chk(bus_addr, 7'h5a);
		wr(`ACC_OFS_GEN, 32'h2);
		chk(ready, 1'b0);
		rd(`ACC_OFS_GEN, d);
		chk(d[1], 1'b1);
		wt(1'b1, 1'b1, RS + 20);
		chk(ready, 1'b1);
		rd(`ACC_OFS_GEN, d);
		chk(d[1], 1'b0);
		rd(`ACC_OFS_STAT, d);
		chk(d[14:8], 7'h12);
		rd(`ACC_OFS_PINF, d);
		chk(d, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
